// File: verilog/gdc_top.v
// APB register block: external interrupt pending flags, debug override config, debug/boot status.
// Assumes APB master on pclk (40 MHz), asynchronous active-low presetn, trigger pulses from
// same-clock detection logic, and debug/strap levels arriving from pins.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`include "gdc_regs.vh"
module gdc_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	input  wire        ext_int_a_trigger,
	input  wire        ext_int_c_trigger,
	input  wire        ext_int_d_trigger,
	input  wire        debug_request,
	input  wire        debugger_cable_forced,
	input  wire        serial_wire_enable_req,
	input  wire        reserved_hw_set,
	input  wire        reserved_hw_clear,
	input  wire        boot_mode_strap_n,
	output wire        debug_override_active,
	output wire        port_a_pin_seven_regen_override,
	output wire        ext_int_pending
);
	// Flag bits, one register each; positions without a flag read as zero
	reg         flag_a_r;
	reg         flag_a_nxt;
	reg         flag_c_r;
	reg         flag_c_nxt;
	reg         flag_d_r;
	reg         flag_d_nxt;
	reg         pending_r;

	// Writable config bits and the reserved bit that hardware also moves
	reg         dbg_dis_r;
	reg         dbg_dis_nxt;
	reg         regen_r;
	reg         regen_nxt;
	reg         rsvd_r;
	reg         rsvd_nxt;

	// Debug session and boot strap capture
	reg         dbg_active_r;
	reg         dbg_active_nxt;
	reg         boot_mode_sampled_r;
	reg         boot_taken_r;
	reg  [2:0]  rst_seen_r;
	reg  [31:0] rd_word;

	// Synchronised pin levels
	wire        forced_sync;
	wire        swen_sync;
	wire        dbgreq_sync;
	wire        strap_sync;

	// Bus decode
	wire        setup_rd;
	wire        access_wr;
	wire        lane0_wr;
	wire        sel_flags;
	wire        sel_cfg;
	wire        sel_stat;
	wire        wr_flags;
	wire        wr_cfg;
	wire [31:0] flags_word;
	wire [31:0] cfg_word;
	wire [31:0] status_word;

	// Reset images, kept whole so single bits can be picked out by position
	localparam [31:0] FLAGS_RST = `GDC_FLAGS_RESET;
	localparam [31:0] CFG_RST   = `GDC_DBGCFG_RESET;
	localparam [31:0] STAT_RST  = `GDC_DBGSTAT_RESET;

	// Address match against one register word; the two byte-offset bits are ignored
	function hit;
		input [31:0] a;
		input [31:0] reg_addr;
		begin
			hit = (a[31:2] == reg_addr[31:2]);
		end
	endfunction

	// Write-1-clear bit with set priority, so an event in the clearing cycle is not lost
	function w1c_next;
		input cur;
		input clr;
		input set;
		begin
			if (set)
				w1c_next = 1'b1;
			else if (clr)
				w1c_next = 1'b0;
			else
				w1c_next = cur;
		end
	endfunction


	// Pin-side inputs come from outside the clock domain
	gdc_sync3 #(.RESET_VAL(1'b0)) u_sync_forced (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (debugger_cable_forced),
		.level_r (forced_sync)
	);
	gdc_sync3 #(.RESET_VAL(1'b0)) u_sync_swen (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (serial_wire_enable_req),
		.level_r (swen_sync)
	);
	gdc_sync3 #(.RESET_VAL(1'b0)) u_sync_dbgreq (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (debug_request),
		.level_r (dbgreq_sync)
	);
	gdc_sync3 #(.RESET_VAL(1'b1)) u_sync_strap (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (boot_mode_strap_n),
		.level_r (strap_sync)
	);


	// Zero-wait slave: pready stays high, so each access ends in its first access cycle
	assign pready    = 1'b1;
	assign pslverr   = 1'b0; // No error cases: unmapped words read zero and ignore writes
	assign setup_rd  = psel & ~penable & ~pwrite;
	assign access_wr = psel & penable & pwrite;
	// Every writable bit sits in byte lane 0, so a write without that lane changes nothing
	assign lane0_wr  = access_wr & pstrb[0];
	assign sel_flags = hit(paddr, `GDC_ADDR_FLAGS);
	assign sel_cfg   = hit(paddr, `GDC_ADDR_DBGCFG);
	assign sel_stat  = hit(paddr, `GDC_ADDR_DBGSTAT);
	assign wr_flags  = lane0_wr & sel_flags;
	assign wr_cfg    = lane0_wr & sel_cfg;

	// Pending flags: write 1 clears, a trigger sets, and the set wins a tie
	always @* begin
		flag_a_nxt = w1c_next(flag_a_r, wr_flags & pwdata[`GDC_FLAG_A_BIT], ext_int_a_trigger);
		flag_c_nxt = w1c_next(flag_c_r, wr_flags & pwdata[`GDC_FLAG_C_BIT], ext_int_c_trigger);
		flag_d_nxt = w1c_next(flag_d_r, wr_flags & pwdata[`GDC_FLAG_D_BIT], ext_int_d_trigger);
	end

	// Flag A storage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flag_a_r <= FLAGS_RST[`GDC_FLAG_A_BIT];
		else
			flag_a_r <= flag_a_nxt;
	end

	// Flag C storage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flag_c_r <= FLAGS_RST[`GDC_FLAG_C_BIT];
		else
			flag_c_r <= flag_c_nxt;
	end

	// Flag D storage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flag_d_r <= FLAGS_RST[`GDC_FLAG_D_BIT];
		else
			flag_d_r <= flag_d_nxt;
	end

	// Summary pending output, registered from the next flag values so it moves
	// on the same edge as the flags themselves and never glitches
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pending_r <= |FLAGS_RST;
		else
			pending_r <= flag_a_nxt | flag_c_nxt | flag_d_nxt;
	end

	// Config update; every writable bit lives in the low byte
	always @* begin
		dbg_dis_nxt = dbg_dis_r;
		regen_nxt   = regen_r;
		rsvd_nxt    = rsvd_r;
		if (wr_cfg) begin
			dbg_dis_nxt = pwdata[`GDC_CFG_DBGDIS_BIT];
			regen_nxt   = pwdata[`GDC_CFG_REGEN_BIT];
			rsvd_nxt    = pwdata[`GDC_CFG_RSVD_BIT];
		end
		// Hardware may move the reserved bit at any time, so it beats the write;
		// software that does not preserve the bit can still lose a hardware change
		if (reserved_hw_set)
			rsvd_nxt = 1'b1;
		else if (reserved_hw_clear)
			rsvd_nxt = 1'b0;
	end

	// Config storage; the regulator override is on from reset until software clears it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbg_dis_r <= CFG_RST[`GDC_CFG_DBGDIS_BIT];
			regen_r   <= CFG_RST[`GDC_CFG_REGEN_BIT];
			rsvd_r    <= CFG_RST[`GDC_CFG_RSVD_BIT];
		end else begin
			dbg_dis_r <= dbg_dis_nxt;
			regen_r   <= regen_nxt;
			rsvd_r    <= rsvd_nxt;
		end
	end

	// Debug override: disable only blocks a new activation, an active session stays
	// until the probe lets its request go
	always @* begin
		if (!dbgreq_sync)
			dbg_active_nxt = 1'b0;
		else if (!dbg_dis_r)
			dbg_active_nxt = 1'b1;
		else
			dbg_active_nxt = dbg_active_r;
	end

	// Debug session storage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dbg_active_r <= 1'b0;
		else
			dbg_active_r <= dbg_active_nxt;
	end

	// Strap capture: the synchroniser restarts from its reset level, so the pin's
	// true level only shows at its output four edges after release; sampling
	// earlier would report the reset level instead of the strap
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_seen_r          <= 3'h0;
			boot_taken_r        <= 1'b0;
			boot_mode_sampled_r <= STAT_RST[`GDC_STAT_BOOT_BIT];
		end else begin
			if (rst_seen_r != `GDC_STRAP_WAIT)
				rst_seen_r <= rst_seen_r + 3'h1;
			if (rst_seen_r == `GDC_STRAP_WAIT && !boot_taken_r) begin
				boot_taken_r        <= 1'b1;
				boot_mode_sampled_r <= ~strap_sync;
			end
		end
	end

	// Register images as software sees them
	assign flags_word  = {28'h0000000, flag_d_r, flag_c_r, 1'b0, flag_a_r};
	assign cfg_word    = {26'h0000000, dbg_dis_r, regen_r, rsvd_r, 3'h0};
	assign status_word = {28'h0000000, boot_mode_sampled_r, 1'b0, forced_sync, swen_sync};

	// Read select; unmapped words read as zero
	always @* begin
		rd_word = 32'h00000000;
		if (sel_flags)
			rd_word = flags_word;
		else if (sel_cfg)
			rd_word = cfg_word;
		else if (sel_stat)
			rd_word = status_word;
	end

	// Read data registered at setup so it stands through the access phase;
	// it then holds until the next read setup, which keeps prdata quiet on writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (setup_rd)
			prdata <= rd_word;
	end

	// Pin-side outputs, all straight from flip-flops
	assign debug_override_active           = dbg_active_r;
	assign port_a_pin_seven_regen_override = regen_r;
	assign ext_int_pending                 = pending_r;
endmodule

// File: verilog/gdc_regs.vh
// Register map, field positions and reset values of the GPIO flag/debug config block.
// Assumes inclusion by bare name; definitions only.
`ifndef GDC_REGS_VH
`define GDC_REGS_VH
`define GDC_ADDR_FLAGS     32'h4000A814
`define GDC_ADDR_DBGCFG    32'h4000BC00
`define GDC_ADDR_DBGSTAT   32'h4000BC04
`define GDC_FLAG_A_BIT     0
`define GDC_FLAG_C_BIT     2
`define GDC_FLAG_D_BIT     3
`define GDC_CFG_RSVD_BIT   3
`define GDC_CFG_REGEN_BIT  4
`define GDC_CFG_DBGDIS_BIT 5
`define GDC_STAT_SWEN_BIT  0
`define GDC_STAT_FORCE_BIT 1
`define GDC_STAT_BOOT_BIT  3
`define GDC_FLAGS_RESET    32'h00000000
`define GDC_DBGCFG_RESET   32'h00000010
`define GDC_DBGSTAT_RESET  32'h00000000
`define GDC_STRAP_WAIT     3'h4
`endif

// File: verilog/gdc_sync3.v
// Three-stage synchroniser with agreement filter for asynchronous pin inputs.
// Assumes one clock pclk and active-low asynchronous reset presetn.
`timescale 1ns/10ps
module gdc_sync3 #(
	parameter RESET_VAL = 1'b0
) (
	input  wire pclk,
	input  wire presetn,
	input  wire pin_in,
	output reg  level_r
);
	reg s1_r;
	reg s2_r;
	reg s3_r;

	// First stage feeds only the second; a change counts once stages two and three agree
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r    <= RESET_VAL;
			s2_r    <= RESET_VAL;
			s3_r    <= RESET_VAL;
			level_r <= RESET_VAL;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				level_r <= s3_r;
		end
	end
endmodule

// File: dv/gdc_chk.sv
// Checker on the ports of gdc_top, bound to it below.
// Assumes one clock pclk and asynchronous active-low presetn.
`timescale 1ns/10ps
`include "gdc_regs.vh"
module gdc_chk (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0]  pstrb,
	input wire        ext_int_a_trigger,
	input wire        ext_int_c_trigger,
	input wire        ext_int_d_trigger,
	input wire        debug_request,
	input wire        debug_override_active,
	input wire        port_a_pin_seven_regen_override,
	input wire        ext_int_pending
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A write is taken only in its access cycle with the low byte strobed
	wire wr = psel && penable && pwrite && pstrb[0];
	wire trg = ext_int_a_trigger | ext_int_c_trigger | ext_int_d_trigger;
	sequence s_cfg_wr;
		wr && paddr == `GDC_ADDR_DBGCFG;
	endsequence
	sequence s_flg_clr;
		wr && paddr == `GDC_ADDR_FLAGS && (pwdata & 32'h0000000D) == 32'h0000000D && !trg;
	endsequence
	a_trig_sets: assert property (trg |=> ext_int_pending) else $error("trigger lost");
	a_pend_hold: assert property (!ext_int_pending && !trg |=> !ext_int_pending) else $error("flag set");
	a_flag_clr: assert property (s_flg_clr |=> !ext_int_pending) else $error("flags not cleared");
	a_regen_rst: assert property ($rose(presetn) |-> port_a_pin_seven_regen_override) else $error("regen");
	a_regen_wr: assert property (s_cfg_wr |=> port_a_pin_seven_regen_override == $past(pwdata[4])) else $error("regen wr");
	a_regen_hold: assert property (!wr |=> $stable(port_a_pin_seven_regen_override)) else $error("regen moved");
	a_dbg_rise: assert property ($rose(debug_override_active) |-> debug_request) else $error("debug rose");
	a_dbg_fall: assert property ($fell(debug_override_active) |-> !debug_request) else $error("debug fell");
endmodule
bind gdc_top gdc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .ext_int_a_trigger,
	.ext_int_c_trigger, .ext_int_d_trigger, .debug_request, .debug_override_active, .port_a_pin_seven_regen_override,
	.ext_int_pending);

// File: dv/gdc_probe.sv
// Debug probe and boot strap model: pin levels {strap_n, swen, forced, request}.
// Assumes the bench sets wanted levels; pins move just after pclk.
`timescale 1ns/10ps
module gdc_probe (
	input  wire       pclk,
	input  wire [3:0] want,
	output reg  [3:0] pins = 4'h0
);
	// Strap starts low so the first reset samples it asserted
	always @(posedge pclk) begin
		pins <= want;
	end
endmodule

// File: dv/gdc_top_bench.sv
// Bench for gdc_top: APB tasks, trigger pulses, probe and strap levels.
// Assumes a 40 MHz pclk; each APB wait is cut off by a bounded count.
`timescale 1ns/10ps
`include "gdc_regs.vh"
module gdc_top_bench;
	reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	reg  [31:0] paddr = 32'h0, pwdata = 32'h0, rd;
	reg  [3:0]  pstrb = 4'hF, want = 4'h0;
	reg  [4:0]  stim = 5'h00;
	wire [3:0]  pins;
	wire        pready, perr, dbg, regen, pend;
	wire [31:0] prdata;
	integer     err_count = 0, total_checks = 0;
	always #12.5 pclk = ~pclk;
	gdc_probe probe (.pclk(pclk), .want(want), .pins(pins));
	gdc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(perr), .prdata(prdata), .ext_int_a_trigger(stim[0]),
		.ext_int_c_trigger(stim[1]), .ext_int_d_trigger(stim[2]), .reserved_hw_set(stim[3]),
		.reserved_hw_clear(stim[4]), .debug_request(pins[0]), .debugger_cable_forced(pins[1]),
		.serial_wire_enable_req(pins[2]), .boot_mode_strap_n(pins[3]), .debug_override_active(dbg),
		.port_a_pin_seven_regen_override(regen), .ext_int_pending(pend));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("ERROR %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	// One APB transfer; tc raises the C trigger in the access cycle
	task apb(input w, input [31:0] a, input [31:0] d, input tc);
		integer n;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			stim[1] <= tc;
			n = 0;
			@(posedge pclk);
			while (pready !== 1'b1 && n < 50) begin
				n = n + 1;
				@(posedge pclk);
			end
			rd = prdata;
			psel <= 1'b0;
			penable <= 1'b0;
			stim[1] <= 1'b0;
		end
	endtask
	task rdc(input [31:0] a, input [31:0] e);
		begin
			apb(1'b0, a, 32'h0, 1'b0);
			chk(rd, e);
		end
	endtask
	task pulse(input [4:0] v);
		begin
			@(posedge pclk);
			stim <= v;
			@(posedge pclk);
			stim <= 5'h00;
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d errors %0d", total_checks, err_count);
			if (err_count == 0 && total_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// Watchdog far beyond the under two hundred cycles the tests need
	initial begin
		#100000;
		err_count = err_count + 1;
		tally_and_finish;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(regen, 1'b1);
		rdc(`GDC_ADDR_FLAGS, 32'h0);
		rdc(`GDC_ADDR_DBGCFG, 32'h10);
		rdc(`GDC_ADDR_DBGSTAT, 32'h8);
		pulse(5'h07);
		rdc(`GDC_ADDR_FLAGS, 32'hD);
		chk({perr, pend}, 2'h1);
		pstrb <= 4'hE;
		apb(1'b1, `GDC_ADDR_FLAGS, 32'hF, 1'b0);
		pstrb <= 4'hF;
		rdc(`GDC_ADDR_FLAGS, 32'hD);
		apb(1'b1, `GDC_ADDR_FLAGS, 32'h0, 1'b0);
		rdc(`GDC_ADDR_FLAGS, 32'hD);
		apb(1'b1, `GDC_ADDR_FLAGS, 32'h1, 1'b0);
		rdc(`GDC_ADDR_FLAGS, 32'hC);
		apb(1'b1, `GDC_ADDR_FLAGS, 32'h8, 1'b0);
		rdc(`GDC_ADDR_FLAGS, 32'h4);
		apb(1'b1, `GDC_ADDR_FLAGS, 32'h4, 1'b1);
		rdc(`GDC_ADDR_FLAGS, 32'h4);
		apb(1'b1, `GDC_ADDR_FLAGS, 32'hF, 1'b0);
		rdc(`GDC_ADDR_FLAGS, 32'h0);
		pulse(5'h08);
		rdc(`GDC_ADDR_DBGCFG, 32'h18);
		apb(1'b1, `GDC_ADDR_DBGCFG, rd & 32'h8, 1'b0);
		@(negedge pclk);
		chk(regen, 1'b0);
		apb(1'b1, 32'h4000BC20, 32'h10, 1'b0);
		rdc(32'h4000BC20, 32'h0);
		rdc(`GDC_ADDR_DBGCFG, 32'h08);
		want <= 4'hF;
		repeat (8) @(posedge pclk);
		chk(dbg, 1'b1);
		rdc(`GDC_ADDR_DBGSTAT, 32'hB);
		apb(1'b1, `GDC_ADDR_DBGCFG, 32'h28, 1'b0);
		repeat (4) @(posedge pclk);
		chk(dbg, 1'b1);
		want <= 4'h8;
		repeat (8) @(posedge pclk);
		want <= 4'h9;
		repeat (8) @(posedge pclk);
		chk(dbg, 1'b0);
		apb(1'b1, `GDC_ADDR_DBGCFG, 32'h18, 1'b0);
		repeat (8) @(posedge pclk);
		chk({regen, dbg}, 2'h3);
		want <= 4'h8;
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		want <= 4'h6;
		repeat (8) @(posedge pclk);
		rdc(`GDC_ADDR_DBGSTAT, 32'h3);
		tally_and_finish;
	end
endmodule
